// file: design/sip_dev.sv
// Purpose: device end of the sensor two-wire register port
// Assumes: link_clk_i far faster than the bus clock
// Notes:   bus lines oversampled, register file outside
// Contract
// [R1] two-wire slave active only while cs high
// [R2] start: data falls while clock high
// [R3] match seven address bits, eighth is direction
// [R4] address 101110 plus address_select_pin level
// [R5] receiver holds data low through ack pulse
// [R6] ack address, sub-address and write bytes
// [R7] sub-address low seven bits, msb ignored
// [R8] auto-increment advances pointer, else fixed
// [R9] master reads via write, pointer, repeated start
// [R10] address byte carries direction as lsb
// [R11] master acks read bytes, nacks last
// [R12] bytes of eight bits, msb first, unlimited
// [R13] no ack leaves data high, master aborts
// [R14] stop: data rises while clock high, idle
// [R15] works at standard and 400 kHz
// [R16] fifo read pointer wraps 7Ch to 78h
// [R17] full fifo drain is five bytes times 128
// [R18] spi alternative selectable three or four wire
// [R19] core power off keeps bus unobstructed
// [R20] on mismatch stay off bus until start
// [R21] lines synchronised, events detected once each
`timescale 1ns/10ps
`default_nettype none
`include "sip_consts.svh"
module sip_dev (
	// link clock and reset
	input  wire logic       link_clk_i,
	input  wire logic       rst_i,
	// bus
	sip_bus_if.dev          bus,
	// configuration
	input  wire logic       core_pwr_ok_i,
	input  wire logic       auto_inc_i,
	input  wire logic       spi_three_wire_i,
	// register file
	output logic      [6:0] reg_addr_o,
	output logic            reg_rd_o,
	input  wire logic [7:0] reg_rdata_i,
	output logic            reg_wr_o,
	output logic      [7:0] reg_wdata_o,
	// status
	output logic            meas_en_o,
	output logic      [1:0] spi_mode_o
);

	// ==========================================================
	// state
	sip_pkg::sip_dev_state_t s;
	sip_pkg::sip_dev_state_t n;

	logic       scl;
	logic       sda;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;
	logic [6:0] own_addr;
	logic [6:0] ptr_inc;

	// ==========================================================
	// line conditioning
	always_comb begin
		scl      = s.scl_sy[1];
		sda      = s.sda_sy[1];
		rise     = scl & ~s.scl_q;                            // R21
		fall     = ~scl & s.scl_q;                            // R21
		start    = scl & s.scl_q & s.sda_q & ~sda;            // R2
		stop     = scl & s.scl_q & ~s.sda_q & sda;            // R14
		own_addr = {`SIP_ADDR_HI, s.sa0_sy[1]};               // R4
		if (!auto_inc_i) begin
			ptr_inc = s.ptr;                                  // R8
		end else if (s.ptr == `SIP_FIFO_TEMP_HI) begin
			ptr_inc = `SIP_FIFO_PRESS_LOW;                    // R16
		end else begin
			ptr_inc = s.ptr + `SIP_PTR_ONE;                   // R8
		end
	end

	// ==========================================================
	// protocol engine
	always_comb begin
		n          = s;
		// two flops on the bus pins and core power before use, R15 by oversampling
		n.scl_sy   = {s.scl_sy[0], bus.scl};                 // R15
		n.sda_sy   = {s.sda_sy[0], bus.sda};
		n.cs_sy    = {s.cs_sy[0], bus.cs};
		n.sa0_sy   = {s.sa0_sy[0], bus.sa0};
		n.pwr_sy   = {s.pwr_sy[0], core_pwr_ok_i};
		n.scl_q    = scl;
		n.sda_q    = sda;
		n.wr       = 1'b0;
		n.rd       = 1'b0;
		n.spi_mode = {~s.cs_sy[1], spi_three_wire_i};          // R18

		// byte fetched one cycle after the request
		if (s.rd) begin
			n.sh     = reg_rdata_i;                           // R12
			n.sda_oe = ~reg_rdata_i[7];
			n.ptr    = ptr_inc;                               // R8
		end

		case (s.st)
			sip_pkg::SIP_D_ADDR: begin
				if (rise) begin
					n.sh  = {s.sh[6:0], sda};                 // R12
					n.cnt = s.cnt + `SIP_BIT_ONE;
				end else if (fall && s.cnt == `SIP_BIT_ACK) begin
					if (s.sh[7:1] == own_addr) begin          // R3
						n.rw     = s.sh[0];                   // R10
						n.sda_oe = 1'b1;                      // R6
						n.st     = sip_pkg::SIP_D_ACK_A;
					end else begin
						n.st     = sip_pkg::SIP_D_IGNORE;     // R13 R20
					end
				end
			end
			sip_pkg::SIP_D_ACK_A: begin
				if (fall) begin
					n.sda_oe = 1'b0;                          // R5
					n.cnt    = 4'h0;
					if (s.rw == `SIP_DIR_READ) begin
						n.rd = 1'b1;                          // R9
						n.st = sip_pkg::SIP_D_TX;
					end else begin
						n.st = sip_pkg::SIP_D_SUB;
					end
				end
			end
			sip_pkg::SIP_D_SUB: begin
				if (rise) begin
					n.sh  = {s.sh[6:0], sda};
					n.cnt = s.cnt + `SIP_BIT_ONE;
				end else if (fall && s.cnt == `SIP_BIT_ACK) begin
					n.ptr    = s.sh[6:0];                     // R7
					n.sda_oe = 1'b1;                          // R6
					n.st     = sip_pkg::SIP_D_ACK_S;
				end
			end
			sip_pkg::SIP_D_ACK_S: begin
				if (fall) begin
					n.sda_oe = 1'b0;                          // R5
					n.cnt    = 4'h0;
					n.st     = sip_pkg::SIP_D_WR;
				end
			end
			sip_pkg::SIP_D_WR: begin
				if (rise) begin
					n.sh  = {s.sh[6:0], sda};
					n.cnt = s.cnt + `SIP_BIT_ONE;
				end else if (fall && s.cnt == `SIP_BIT_ACK) begin
					n.wr     = 1'b1;
					n.wdata  = s.sh;
					n.sda_oe = 1'b1;                          // R6
					n.st     = sip_pkg::SIP_D_ACK_W;
				end
			end
			sip_pkg::SIP_D_ACK_W: begin
				if (fall) begin
					n.sda_oe = 1'b0;                          // R5
					n.cnt    = 4'h0;
					n.ptr    = ptr_inc;                       // R8
					n.st     = sip_pkg::SIP_D_WR;             // R12
				end
			end
			sip_pkg::SIP_D_TX: begin
				if (rise) begin
					n.cnt = s.cnt + `SIP_BIT_ONE;
				end else if (fall) begin
					if (s.cnt == `SIP_BIT_ACK) begin
						n.sda_oe = 1'b0;                      // R5
						n.cnt    = 4'h0;
						n.st     = sip_pkg::SIP_D_MACK;
					end else begin
						n.sh     = {s.sh[6:0], 1'b1};         // R12
						n.sda_oe = ~s.sh[6];
					end
				end
			end
			sip_pkg::SIP_D_MACK: begin
				if (rise) begin
					if (sda) begin
						n.st = sip_pkg::SIP_D_IGNORE;         // R11
					end else begin
						n.cnt = `SIP_BIT_ONE;
					end
				end else if (fall && s.cnt == `SIP_BIT_ONE) begin
					n.cnt = 4'h0;
					n.rd  = 1'b1;                             // R11
					n.st  = sip_pkg::SIP_D_TX;
				end
			end
			sip_pkg::SIP_D_IGNORE: begin
				n.sda_oe = 1'b0;                              // R20
			end
			sip_pkg::SIP_D_IDLE: begin
				n.sda_oe = 1'b0;
			end
			default: begin
				n.st     = sip_pkg::SIP_D_IDLE;
				n.sda_oe = 1'b0;
			end
		endcase

		if (start) begin
			n.st     = sip_pkg::SIP_D_ADDR;                   // R2
			n.cnt    = 4'h0;
			n.sda_oe = 1'b0;
			n.rd     = 1'b0;
		end else if (stop) begin
			n.st     = sip_pkg::SIP_D_IDLE;                   // R14
			n.sda_oe = 1'b0;
			n.rd     = 1'b0;
		end
		if (!s.cs_sy[1]) begin
			n.st     = sip_pkg::SIP_D_IDLE;                   // R1
			n.sda_oe = 1'b0;
			n.rd     = 1'b0;
			n.wr     = 1'b0;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// outputs
	assign bus.sda_s_o  = 1'b0;
	assign bus.sda_s_oe = s.sda_oe;
	assign reg_addr_o   = s.ptr;
	assign reg_rd_o     = s.rd;
	assign reg_wr_o     = s.wr;
	assign reg_wdata_o  = s.wdata;
	// bus logic never gated by core power
	assign meas_en_o    = s.pwr_sy[1];                        // R19
	assign spi_mode_o   = s.spi_mode;

endmodule : sip_dev
`default_nettype wire

// file: design/sip_consts.svh
// Purpose: shared constants of the sensor two-wire register port
// Assumes: included by bare name
// Notes:   times in ns, counts derived from them
`ifndef SIP_CONSTS_SVH
`define SIP_CONSTS_SVH

// ==============================================================
// addressing
`define SIP_ADDR_HI        6'h2E
`define SIP_DIR_READ       1'h1
`define SIP_DIR_WRITE      1'h0

// ==============================================================
// fifo output window
`define SIP_FIFO_PRESS_LOW 7'h78
`define SIP_FIFO_PRESS_MID 7'h79
`define SIP_FIFO_PRESS_HI  7'h7A
`define SIP_FIFO_TEMP_LOW  7'h7B
`define SIP_FIFO_TEMP_HI   7'h7C

// ==============================================================
// framing
`define SIP_BIT_ACK        4'h8
`define SIP_BIT_ONE        4'h1
`define SIP_PTR_ONE        7'h01
`define SIP_BYTE_ONE       8'h01

// ==============================================================
// timing
`define SIP_CLK_PERIOD_NS  10
`define SIP_SCL_PERIOD_NS  2500
`define SIP_QTR_CYC        ((`SIP_SCL_PERIOD_NS / 4 + `SIP_CLK_PERIOD_NS - 1) / `SIP_CLK_PERIOD_NS)

`endif

// file: design/sip_pkg.sv
// Purpose: types of the sensor two-wire register port
// Assumes: nothing
// Notes:   state of each end is one packed struct
package sip_pkg;

	// ==========================================================
	// device end
	typedef enum logic [3:0] {
		SIP_D_IDLE, SIP_D_ADDR, SIP_D_ACK_A, SIP_D_SUB, SIP_D_ACK_S,
		SIP_D_WR, SIP_D_ACK_W, SIP_D_TX, SIP_D_MACK, SIP_D_IGNORE
	} sip_dev_st_t;

	typedef struct packed {
		logic [1:0]  scl_sy;
		logic [1:0]  sda_sy;
		logic [1:0]  cs_sy;
		logic [1:0]  sa0_sy;
		logic [1:0]  pwr_sy;
		logic        scl_q;
		logic        sda_q;
		sip_dev_st_t st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic        rw;
		logic [6:0]  ptr;
		logic        sda_oe;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
		logic [1:0]  spi_mode;
	} sip_dev_state_t;

	// ==========================================================
	// host end
	typedef enum logic [2:0] {
		SIP_H_IDLE, SIP_H_START, SIP_H_ADDR, SIP_H_SUB, SIP_H_WDATA,
		SIP_H_RADDR, SIP_H_RDATA, SIP_H_STOP
	} sip_host_st_t;

	typedef struct packed {
		logic [1:0]   sda_sy;
		sip_host_st_t st;
		logic [15:0]  qcnt;
		logic [1:0]   ph;
		logic [3:0]   bitn;
		logic [7:0]   sh;
		logic [7:0]   rem;
		logic         rd;
		logic         rph;
		logic         dsel;
		logic [7:0]   sub;
		logic         scl;
		logic         oe;
		logic         nack;
		logic         done;
		logic [7:0]   rdata;
		logic         rvalid;
		logic         take;
	} sip_host_state_t;

endpackage : sip_pkg

// file: design/sip_bus_if.sv
// Purpose: two-wire bus between host end and device end
// Assumes: pull-ups on both lines, open-drain data
// Notes:   data line resolved here from both enables
`timescale 1ns/10ps
`default_nettype none
interface sip_bus_if;
	logic scl;
	logic sda;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic cs;
	logic sa0;

	// wired-and with pull-up
	assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

	modport host (output scl, sda_m_o, sda_m_oe, cs, input sda);
	modport dev  (input scl, sda, cs, sa0, output sda_s_o, sda_s_oe);
endinterface : sip_bus_if
`default_nettype wire

// file: design/sip_host.sv
// Purpose: bus master end of the sensor two-wire register port
// Assumes: clk_i at 100 MHz, bus clock from divider
// Notes:   one command per transaction, reads need length of one or more
`timescale 1ns/10ps
`default_nettype none
`include "sip_consts.svh"
module sip_host #(
	parameter logic [15:0] QTR = 16'(`SIP_QTR_CYC)
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// bus
	sip_bus_if.host         bus,
	// command
	input  wire logic       cmd_valid_i,
	output logic            cmd_ready_o,
	input  wire logic       cmd_read_i,
	input  wire logic       cmd_dev_sel_i,
	input  wire logic [7:0] cmd_sub_i,
	input  wire logic [7:0] cmd_len_i,
	// write data
	input  wire logic [7:0] wdata_i,
	output logic            wdata_take_o,
	// read data and status
	output logic      [7:0] rdata_o,
	output logic            rdata_valid_o,
	output logic            done_o,
	output logic            nack_o
);

	// ==========================================================
	// state
	sip_pkg::sip_host_state_t s;
	sip_pkg::sip_host_state_t n;

	logic tick;
	logic sda;
	logic tx;
	logic scl_c;
	logic oe_c;

	always_comb begin
		tick = (s.qcnt == 16'h0000);
		sda  = s.sda_sy[1];
		tx   = (s.st != sip_pkg::SIP_H_RDATA);
		case (s.st)
			sip_pkg::SIP_H_IDLE: begin
				scl_c = 1'b1;
				oe_c  = 1'b0;
			end
			sip_pkg::SIP_H_START: begin
				scl_c = (s.ph != 2'h0);
				oe_c  = s.ph[1];                              // R2
			end
			sip_pkg::SIP_H_STOP: begin
				scl_c = (s.ph != 2'h0);
				oe_c  = ~s.ph[1];                             // R14
			end
			default: begin
				scl_c = s.ph[1];
				if (s.bitn != `SIP_BIT_ACK) begin
					oe_c = tx & ~s.sh[7];                     // R12
				end else begin
					oe_c = ~tx & (s.rem > `SIP_BYTE_ONE);     // R5 R11
				end
			end
		endcase
	end

	// ==========================================================
	// sequencer
	always_comb begin
		n        = s;
		n.sda_sy = {s.sda_sy[0], bus.sda};
		n.scl    = scl_c;
		n.oe     = oe_c;
		n.done   = 1'b0;
		n.rvalid = 1'b0;
		n.take   = 1'b0;
		n.qcnt   = tick ? QTR - 16'h0001 : s.qcnt - 16'h0001;

		if (s.st == sip_pkg::SIP_H_IDLE) begin
			n.qcnt = QTR - 16'h0001;
			if (cmd_valid_i) begin
				n.st   = sip_pkg::SIP_H_START;
				n.ph   = 2'h0;
				n.rd   = cmd_read_i;
				n.dsel = cmd_dev_sel_i;
				n.sub  = cmd_sub_i;
				n.rem  = cmd_len_i;
				n.rph  = 1'b0;
				n.nack = 1'b0;
			end
		end else if (tick && s.ph != 2'h3) begin
			n.ph = s.ph + 2'h1;
			if (s.ph == 2'h2 && s.st != sip_pkg::SIP_H_START && s.st != sip_pkg::SIP_H_STOP) begin
				if (s.bitn == `SIP_BIT_ACK && tx) begin
					n.nack = sda;                             // R13
				end else if (s.bitn != `SIP_BIT_ACK && !tx) begin
					n.sh = {s.sh[6:0], sda};                  // R12
				end
			end
		end else if (tick) begin
			n.ph = 2'h0;
			case (s.st)
				sip_pkg::SIP_H_START: begin
					n.bitn = 4'h0;
					n.sh   = {`SIP_ADDR_HI, s.dsel, s.rph};   // R10
					n.st   = s.rph ? sip_pkg::SIP_H_RADDR : sip_pkg::SIP_H_ADDR;
				end
				sip_pkg::SIP_H_STOP: begin
					n.st   = sip_pkg::SIP_H_IDLE;
					n.done = 1'b1;
				end
				default: begin
					if (s.bitn != `SIP_BIT_ACK) begin
						n.bitn = s.bitn + `SIP_BIT_ONE;
						if (tx) begin
							n.sh = {s.sh[6:0], 1'b1};
						end else if (s.bitn == 4'h7) begin
							n.rdata  = s.sh;
							n.rvalid = 1'b1;
						end
					end else begin
						n.bitn = 4'h0;
						if (tx && s.nack) begin
							n.st = sip_pkg::SIP_H_STOP;       // R13
						end else begin
							case (s.st)
								sip_pkg::SIP_H_ADDR: begin
									n.st = sip_pkg::SIP_H_SUB;
									n.sh = s.sub;
								end
								sip_pkg::SIP_H_SUB: begin
									if (s.rd) begin
										n.rph = 1'b1;         // R9
										n.st  = sip_pkg::SIP_H_START;
									end else if (s.rem == 8'h00) begin
										n.st  = sip_pkg::SIP_H_STOP;
									end else begin
										n.st   = sip_pkg::SIP_H_WDATA;
										n.sh   = wdata_i;
										n.take = 1'b1;
									end
								end
								sip_pkg::SIP_H_WDATA: begin
									n.rem = s.rem - `SIP_BYTE_ONE;
									if (s.rem == `SIP_BYTE_ONE) begin
										n.st = sip_pkg::SIP_H_STOP;
									end else begin
										n.sh   = wdata_i;
										n.take = 1'b1;
									end
								end
								sip_pkg::SIP_H_RADDR: begin
									n.st = sip_pkg::SIP_H_RDATA;
								end
								default: begin
									n.rem = s.rem - `SIP_BYTE_ONE;
									if (s.rem <= `SIP_BYTE_ONE) begin
										n.st = sip_pkg::SIP_H_STOP; // R11 R14
									end
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// outputs
	assign bus.scl       = s.scl;
	assign bus.sda_m_o   = 1'b0;
	assign bus.sda_m_oe  = s.oe;
	assign bus.cs        = 1'b1;                              // R1
	assign cmd_ready_o   = (s.st == sip_pkg::SIP_H_IDLE);
	assign wdata_take_o  = s.take;
	assign rdata_o       = s.rdata;
	assign rdata_valid_o = s.rvalid;
	assign done_o        = s.done;
	assign nack_o        = s.nack;

endmodule : sip_host
`default_nettype wire

// file: verif/sip_assertions.sv
// Purpose: bus checks for both ends of the two-wire register port
// Assumes: host clock far faster than the bus clock
// Notes:   framing tracked in the host clock domain
`timescale 1ns/10ps
`default_nettype none
`include "sip_consts.svh"
module sip_assertions (
	// clocks and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic link_rst_i,
	// bus
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic cs,
	input wire logic sa0
);
	// ========
	// framing tracker
	logic [3:0] bitc;
	logic [7:0] sh;
	logic       first;
	logic       matched;
	logic       rdir;
	logic       busy;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{bitc, sh, first, matched, rdir, busy} <= '0;
		end else if (scl && $past(scl) && $changed(sda)) begin
			bitc <= 4'h0;
			first <= !sda;
			busy <= !sda;
		end else if ($rose(scl) && busy) begin
			bitc <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
			if (bitc < 4'h8) sh <= {sh[6:0], sda};
			if (bitc == 4'h8 && first) begin
				first <= 1'h0;
				matched <= (sh[7:1] == {`SIP_ADDR_HI, sa0});
				rdir <= sh[0];
			end
		end
	end
	// ========
	// checks
	a_dev_edge_low: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
		$changed(sda_s_oe) |-> !scl) else $error("device data changed while clock high");
	a_frame_edges: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(sda_m_oe) && scl && $past(scl) |-> bitc == (busy ? 4'h1 : 4'h0))
		else $error("host data changed while clock high inside a byte");
	a_addr_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(scl) && busy && bitc == 4'h8 && first |-> sda_s_oe == (sh[7:1] == {`SIP_ADDR_HI, sa0}))
		else $error("address acknowledge wrong");
	a_data_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(scl) && busy && bitc == 4'h8 && !first && matched |-> sda_s_oe == !rdir)
		else $error("data acknowledge slot wrong");
	a_quiet_off_bus: assert property (@(posedge clk_i) disable iff (rst_i)
		!busy || (!first && !matched) |-> !sda_s_oe) else $error("device drives while not addressed");
	a_one_driver: assert property (@(posedge clk_i) disable iff (rst_i)
		scl && sda_s_oe |-> !sda_m_oe) else $error("both ends drive data in clock high");
	a_start_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		scl && $past(scl) && $fell(sda) |-> scl [*8]) else $error("start hold too short");
	a_stop_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		scl && $past(scl) && $rose(sda) |-> (scl && sda) [*8]) else $error("bus not idle after stop");
	a_cs_held: assert property (@(posedge clk_i) disable iff (rst_i)
		cs) else $error("select line low");
endmodule : sip_assertions
`default_nettype wire

// file: verif/sensor_i2c_register_port_tb.sv
// Purpose: bench for both ends of the two-wire register port
// Assumes: host clock 100 MHz, link clock 30 ns
// Notes:   register file modelled here, fifo window read-only
`timescale 1ns/10ps
`default_nettype none
`include "sip_consts.svh"
module sensor_i2c_register_port_tb;
	typedef struct packed {
		logic       rd;
		logic       sa0;
		logic       sel;
		logic [7:0] sub;
		logic [7:0] len;
		logic [7:0] base;
		logic       ainc;
	} sip_row_t;
	localparam sip_row_t ROWS [12] = '{
		'{1'h0, 1'h0, 1'h0, 8'h10, 8'h03, 8'h31, 1'h1}, '{1'h1, 1'h0, 1'h0, 8'h10, 8'h03, 8'h00, 1'h1},
		'{1'h0, 1'h1, 1'h1, 8'h85, 8'h01, 8'h5A, 1'h1}, '{1'h1, 1'h1, 1'h1, 8'h05, 8'h01, 8'h00, 1'h1},
		'{1'h1, 1'h0, 1'h0, 8'h7B, 8'h04, 8'h00, 1'h1}, '{1'h0, 1'h0, 1'h0, 8'h20, 8'h02, 8'hC0, 1'h0},
		'{1'h1, 1'h0, 1'h0, 8'h20, 8'h02, 8'h00, 1'h0}, '{1'h0, 1'h0, 1'h1, 8'h30, 8'h01, 8'h77, 1'h1},
		'{1'h1, 1'h1, 1'h0, 8'h10, 8'h02, 8'h00, 1'h1}, '{1'h1, 1'h0, 1'h0, 8'h30, 8'h01, 8'h00, 1'h1},
		'{1'h0, 1'h0, 1'h0, 8'h7C, 8'h02, 8'hE0, 1'h1}, '{1'h1, 1'h0, 1'h0, 8'h7C, 8'h03, 8'h00, 1'h1}};
	// ========
	// stimulus and observation
	logic        clk_i = 1'h0, rst_i = 1'h1, link_clk_i = 1'h0, link_rst_i = 1'h1;
	logic        cmd_valid = 1'h0, cmd_read = 1'h0, cmd_sel = 1'h0, cmd_ready, wtake, rvalid, done, nack;
	logic        sa0 = 1'h0, core_pwr = 1'h1, auto_inc = 1'h1, three_wire = 1'h0, reg_wr, reg_rd, meas_en;
	int          n_rd = 0;
	logic [7:0]  cmd_sub = 8'h00, cmd_len = 8'h00, wdata = 8'h00, wbase = 8'h00, widx = 8'h00;
	logic [7:0]  rdata, reg_rdata, reg_wdata;
	logic [6:0]  reg_addr;
	logic [1:0]  spi_mode;
	logic [7:0]  mem [128];
	logic [7:0]  exp_mem [128];
	logic [14:0] wq [$];
	logic [7:0]  rq [$];
	int          n_mismatch = 0, n_compared = 0;
	sip_bus_if u_sip_bus_if ();
	assign u_sip_bus_if.sa0 = sa0;
	assign reg_rdata = mem[reg_addr];
	sip_host #(.QTR(16'h000C)) u_sip_host (.clk_i(clk_i), .rst_i(rst_i), .bus(u_sip_bus_if.host),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read), .cmd_dev_sel_i(cmd_sel),
		.cmd_sub_i(cmd_sub), .cmd_len_i(cmd_len), .wdata_i(wdata), .wdata_take_o(wtake),
		.rdata_o(rdata), .rdata_valid_o(rvalid), .done_o(done), .nack_o(nack));
	sip_dev u_sip_dev (.link_clk_i(link_clk_i), .rst_i(link_rst_i), .bus(u_sip_bus_if.dev),
		.core_pwr_ok_i(core_pwr), .auto_inc_i(auto_inc), .spi_three_wire_i(three_wire),
		.reg_addr_o(reg_addr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr),
		.reg_wdata_o(reg_wdata), .meas_en_o(meas_en), .spi_mode_o(spi_mode));
	sip_assertions u_sip_assertions (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
		.link_rst_i(link_rst_i), .scl(u_sip_bus_if.scl), .sda(u_sip_bus_if.sda),
		.sda_m_oe(u_sip_bus_if.sda_m_oe), .sda_s_oe(u_sip_bus_if.sda_s_oe), .cs(u_sip_bus_if.cs), .sa0(sa0));
	always #5 clk_i = ~clk_i;
	initial begin
		#2.3;
		forever #15 link_clk_i = ~link_clk_i;
	end
	always @(posedge link_clk_i) begin
		if (reg_rd === 1'h1) n_rd++;
		if (reg_wr === 1'h1) begin
			wq.push_back({reg_addr, reg_wdata});
			if (!ro(reg_addr)) mem[reg_addr] <= reg_wdata;
		end
	end
	always @(posedge clk_i) begin
		if (rvalid === 1'h1) rq.push_back(rdata);
		if (wtake === 1'h1) begin
			widx <= widx + 8'h01;
			wdata <= wbase + widx + 8'h01;
		end
	end
	// ========
	// helpers
	function automatic logic ro(input logic [6:0] a);
		return a >= `SIP_FIFO_PRESS_LOW && a <= `SIP_FIFO_TEMP_HI;
	endfunction : ro
	function automatic logic [6:0] nxt(input logic [6:0] p, input logic ainc);
		if (!ainc) return p;
		return (p == `SIP_FIFO_TEMP_HI) ? `SIP_FIFO_PRESS_LOW : p + 7'h01;
	endfunction : nxt
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk_byte
	task automatic chk_bit(input string what, input logic e, input logic g);
		chk_byte(what, {7'h00, e}, {7'h00, g});
	endtask : chk_bit
	task automatic run_row(input sip_row_t r);
		logic [6:0] p;
		logic       bad;
		int         t;
		int         rd0;
		p = r.sub[6:0];
		bad = (r.sel != r.sa0);
		{sa0, auto_inc, cmd_read, cmd_sel, cmd_sub, cmd_len} = {r.sa0, r.ainc, r.rd, r.sel, r.sub, r.len};
		{wbase, wdata, widx} = {r.base, r.base, 8'h00};
		wq.delete();
		rq.delete();
		rd0 = n_rd;
		cyc(20);
		cmd_valid = 1'h1;
		cyc(1);
		cmd_valid = 1'h0;
		for (t = 0; t < 8000 && done !== 1'h1; t++) cyc(1);
		chk_bit("done", 1'h1, done);
		chk_bit("nack", bad, nack);
		if (bad) chk_byte("wr_count", 8'h00, 8'(wq.size()));
		else if (!r.rd) begin
			chk_byte("wr_count", r.len, 8'(wq.size()));
			for (t = 0; t < wq.size(); t++) begin
				chk_byte("wr_addr", {1'h0, p}, {1'h0, wq[t][14:8]});
				chk_byte("wr_data", r.base + 8'(t), wq[t][7:0]);
				if (!ro(p)) exp_mem[p] = r.base + 8'(t);
				p = nxt(p, r.ainc);
			end
		end else begin
			chk_byte("rd_count", r.len, 8'(rq.size()));
			chk_byte("rd_fetch", r.len, 8'(n_rd - rd0));
			for (t = 0; t < rq.size(); t++) begin
				chk_byte("rd_data", exp_mem[p], rq[t]);
				p = nxt(p, r.ainc);
			end
		end
		$display("test done rd=%0d sub=%h len=%0d", r.rd, r.sub, r.len);
	endtask : run_row
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	// ========
	// sequence
	initial begin
		#600000;
		n_mismatch++;
		$display("watchdog expired");
		wrap_up();
	end
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i * 7 + 3);
			exp_mem[i] = 8'(i * 7 + 3);
		end
		cyc(5);
		rst_i = 1'h0;
		cyc(10);
		link_rst_i = 1'h0;
		cyc(30);
		foreach (ROWS[i]) run_row(ROWS[i]);
		// bus stays usable with the core unpowered
		core_pwr = 1'h0;
		cyc(20);
		chk_bit("meas_en", 1'h0, meas_en);
		run_row(ROWS[1]);
		core_pwr = 1'h1;
		three_wire = 1'h1;
		cyc(20);
		chk_bit("meas_en", 1'h1, meas_en);
		chk_byte("spi_mode", 8'h01, {6'h00, spi_mode});
		$display("test power and mode done");
		rst_i = 1'h1;
		link_rst_i = 1'h1;
		cyc(15);
		chk_bit("ready_rst", 1'h1, cmd_ready);
		chk_bit("scl_rst", 1'h0, u_sip_bus_if.scl);
		chk_bit("oe_rst", 1'h0, u_sip_bus_if.sda_s_oe);
		chk_byte("ptr_rst", 8'h00, {1'h0, reg_addr});
		rst_i = 1'h0;
		link_rst_i = 1'h0;
		cyc(30);
		run_row(ROWS[4]);
		// two whole fifo levels in one burst
		run_row('{1'h1, 1'h0, 1'h0, 8'h78, 8'h0A, 8'h00, 1'h1});
		$display("test reset done");
		wrap_up();
	end
endmodule : sensor_i2c_register_port_tb
`default_nettype wire
